//--- icv_core_model.sv
// file: behavioural model of the core that takes vectors, wake-ups and returns
`timescale 1ns/100ps
module icv_core_model (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire icv_pkg::icv_vec_s i_vec,
  input wire logic i_wake,
  input wire logic i_wake_to_vector,
  input wire logic i_ret_cmd,
  output logic o_return_from_handler,
  output logic [icv_pkg::PC_W-1:0] o_pc
);
  logic [icv_pkg::PC_W-1:0] ret_stack [8];
  logic [2:0] depth;

  // ----------------------------------------------------------------
  // program counter and return stack
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pc <= '0;
      depth <= '0;
    end else if (i_vec.take) begin
      ret_stack[depth] <= o_pc;
      depth <= depth + 3'h1;
      o_pc <= i_vec.vec_addr;
    end else if (o_return_from_handler && depth != 3'h0) begin
      depth <= depth - 3'h1;
      o_pc <= ret_stack[depth - 3'h1];
    end else if (i_wake) begin
      o_pc <= i_wake_to_vector ? i_vec.vec_addr : o_pc + 13'h0001;
    end
  end

  // ----------------------------------------------------------------
  // one-cycle return instruction per command
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_return_from_handler <= 1'b0;
    end else begin
      o_return_from_handler <= i_ret_cmd;
    end
  end
endmodule

//--- icv_irq_ctrl.sv
// module: interrupt flags, enables, vectoring and wake-up control
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
module icv_irq_ctrl #(
  parameter int PERIPH_N = 5
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire icv_pkg::icv_bus_req_s i_bus,
  output logic [icv_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_ext_irq_pin,
  input wire logic [icv_pkg::PORT_CHANGE_W-1:0] i_second_io_port_hi,
  input wire logic i_timer_overflow,
  input wire logic [PERIPH_N-1:0] i_periph_evt,
  input wire logic i_return_from_handler,
  input wire logic i_sleep,
  output icv_pkg::icv_vec_s o_vec,
  output logic o_wake,
  output logic o_wake_to_vector
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (PERIPH_N < 1 || PERIPH_N > icv_pkg::MAX_SOURCES - icv_pkg::CORE_SOURCES) begin : g_bad_n
    $error("PERIPH_N out of range");
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [icv_pkg::DATA_W-1:0] irq_control_reg;
  logic [PERIPH_N-1:0] periph_flag_reg;
  logic [PERIPH_N-1:0] periph_enable_reg;
  logic [icv_pkg::DATA_W-1:0] option_reg;
  logic ext_sync;
  logic ext_prev;
  logic [icv_pkg::PORT_CHANGE_W-1:0] port_sync;
  logic [icv_pkg::PORT_CHANGE_W-1:0] port_prev;
  logic [1:0] prime_cnt;
  logic sync_primed;
  logic ext_evt;
  logic port_evt;
  logic wr_ctrl;
  logic wr_pflag;
  logic wr_pen;
  logic wr_option;
  logic [1:0] qcnt;
  logic boundary;
  logic [1:0] lat_cnt;
  logic take_req;
  logic take_now;
  logic wake_req;
  logic wake_sent;
  logic sleep_prev;
  logic ext_en_at_sleep;
  logic global_irq_enable;
  logic [icv_pkg::DATA_W-1:0] next_rdata;

  assign global_irq_enable = irq_control_reg[icv_pkg::GLOBAL_IRQ_ENABLE_BIT];

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic core_req(input logic [icv_pkg::DATA_W-1:0] ctl);
    core_req = (ctl[icv_pkg::EXT_PIN_FLAG_BIT] && ctl[icv_pkg::EXT_PIN_ENABLE_BIT])
      || (ctl[icv_pkg::TIMER_OVERFLOW_FLAG_BIT] && ctl[icv_pkg::TIMER_OVERFLOW_ENABLE_BIT])
      || (ctl[icv_pkg::PORT_CHANGE_FLAG_BIT] && ctl[icv_pkg::PORT_CHANGE_ENABLE_BIT]);
  endfunction

  function automatic logic periph_req(input logic [icv_pkg::DATA_W-1:0] ctl,
                                      input logic [PERIPH_N-1:0] flg,
                                      input logic [PERIPH_N-1:0] ena);
    periph_req = ctl[icv_pkg::PERIPH_GROUP_ENABLE_BIT] && |(flg & ena);
  endfunction

  function automatic logic [icv_pkg::DATA_W-1:0] widen(input logic [PERIPH_N-1:0] v);
    widen = icv_pkg::READ_ZERO;
    widen[PERIPH_N-1:0] = v;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  icv_pin_sync #(
    .WIDTH(1)
  ) u_ext_sync (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_async(i_ext_irq_pin),
    .o_sync(ext_sync)
  );

  icv_pin_sync #(
    .WIDTH(icv_pkg::PORT_CHANGE_W)
  ) u_port_sync (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_async(i_second_io_port_hi),
    .o_sync(port_sync)
  );

  // ----------------------------------------------------------------
  // edge and change detection
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      ext_prev <= 1'b0;
      port_prev <= '0;
      prime_cnt <= 2'h0;
    end else begin
      ext_prev <= ext_sync;
      port_prev <= port_sync;
      prime_cnt <= prime_cnt + 2'(!sync_primed);
    end
  end

  // detection waits until both sync stages and prev hold real pin levels
  assign sync_primed = &prime_cnt;

  always_comb begin
    if (option_reg[icv_pkg::EXT_EDGE_SELECT_BIT]) begin
      ext_evt = sync_primed && ext_sync && !ext_prev;
    end else begin
      ext_evt = sync_primed && !ext_sync && ext_prev;
    end
    port_evt = sync_primed && (port_sync != port_prev);
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  assign wr_ctrl = i_bus.wr && (i_bus.addr == icv_pkg::ADDR_IRQ_CONTROL);
  assign wr_pflag = i_bus.wr && (i_bus.addr == icv_pkg::ADDR_PERIPH_FLAG);
  assign wr_pen = i_bus.wr && (i_bus.addr == icv_pkg::ADDR_PERIPH_ENABLE);
  assign wr_option = i_bus.wr && (i_bus.addr == icv_pkg::ADDR_OPTION);

  // control register: enables, core flags and global enable
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_control_reg <= icv_pkg::IRQ_CONTROL_RST;
    end else begin
      if (wr_ctrl) begin
        irq_control_reg <= i_bus.wdata;
      end
      // handler return re-arms, taking disarms; taking wins
      if (i_return_from_handler) begin
        irq_control_reg[icv_pkg::GLOBAL_IRQ_ENABLE_BIT] <= 1'b1;
      end
      if (take_now) begin
        irq_control_reg[icv_pkg::GLOBAL_IRQ_ENABLE_BIT] <= 1'b0;
      end
      // events set flags over any software clear
      if (ext_evt) begin
        irq_control_reg[icv_pkg::EXT_PIN_FLAG_BIT] <= 1'b1;
      end
      if (i_timer_overflow) begin
        irq_control_reg[icv_pkg::TIMER_OVERFLOW_FLAG_BIT] <= 1'b1;
      end
      if (port_evt) begin
        irq_control_reg[icv_pkg::PORT_CHANGE_FLAG_BIT] <= 1'b1;
      end
    end
  end

  // peripheral flags, own register
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      periph_flag_reg <= icv_pkg::PERIPH_FLAG_RST[PERIPH_N-1:0];
    end else begin
      periph_flag_reg <= (wr_pflag ? i_bus.wdata[PERIPH_N-1:0] : periph_flag_reg)
        | i_periph_evt;
    end
  end

  // peripheral enables, own register
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      periph_enable_reg <= icv_pkg::PERIPH_ENABLE_RST[PERIPH_N-1:0];
    end else if (wr_pen) begin
      periph_enable_reg <= i_bus.wdata[PERIPH_N-1:0];
    end
  end

  // option register, edge select
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      option_reg <= icv_pkg::OPTION_RST;
    end else if (wr_option) begin
      option_reg <= i_bus.wdata;
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = icv_pkg::READ_ZERO;
    if (i_bus.rd) begin
      unique case (i_bus.addr)
        icv_pkg::ADDR_IRQ_CONTROL: next_rdata = irq_control_reg;
        icv_pkg::ADDR_PERIPH_FLAG: next_rdata = widen(periph_flag_reg);
        icv_pkg::ADDR_PERIPH_ENABLE: next_rdata = widen(periph_enable_reg);
        icv_pkg::ADDR_OPTION: next_rdata = option_reg;
        default: next_rdata = icv_pkg::READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= icv_pkg::READ_ZERO;
    end else begin
      o_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // instruction-cycle phase and vector latency
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      qcnt <= 2'h0;
    end else begin
      qcnt <= (qcnt == 2'(icv_pkg::Q_PER_ICYC - 1)) ? 2'h0 : qcnt + 2'h1;
    end
  end

  assign boundary = (qcnt == 2'(icv_pkg::Q_PER_ICYC - 1));

  assign wake_req = core_req(irq_control_reg)
    || periph_req(irq_control_reg, periph_flag_reg, periph_enable_reg);
  assign take_req = global_irq_enable && wake_req && !i_sleep;
  assign take_now = take_req && boundary
    && (lat_cnt == 2'(icv_pkg::LAT_ICYC - 1));

  // count instruction boundaries while a request stands
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      lat_cnt <= 2'h0;
    end else if (!take_req || take_now) begin
      lat_cnt <= 2'h0;
    end else if (boundary) begin
      lat_cnt <= lat_cnt + 2'h1;
    end
  end

  // vector output to the core: push return and load vector
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_vec <= '0;
    end else begin
      o_vec.take <= take_now;
      o_vec.vec_addr <= icv_pkg::IRQ_VECTOR;
    end
  end

  // ----------------------------------------------------------------
  // sleep and wake-up
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      sleep_prev <= 1'b0;
      ext_en_at_sleep <= 1'b0;
    end else begin
      sleep_prev <= i_sleep;
      if (i_sleep && !sleep_prev) begin
        ext_en_at_sleep <= irq_control_reg[icv_pkg::EXT_PIN_ENABLE_BIT];
      end
    end
  end

  // pin wakes only with the enable held at sleep entry
  logic sleep_wake;
  assign sleep_wake = (irq_control_reg[icv_pkg::EXT_PIN_FLAG_BIT] && ext_en_at_sleep)
    || (irq_control_reg[icv_pkg::TIMER_OVERFLOW_FLAG_BIT]
        && irq_control_reg[icv_pkg::TIMER_OVERFLOW_ENABLE_BIT])
    || (irq_control_reg[icv_pkg::PORT_CHANGE_FLAG_BIT]
        && irq_control_reg[icv_pkg::PORT_CHANGE_ENABLE_BIT])
    || periph_req(irq_control_reg, periph_flag_reg, periph_enable_reg);

  // one wake pulse per sleep; registers are left as they stand
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_wake <= 1'b0;
      wake_sent <= 1'b0;
      o_wake_to_vector <= 1'b0;
    end else begin
      o_wake <= i_sleep && sleep_prev && sleep_wake && !wake_sent;
      if (!i_sleep) begin
        wake_sent <= 1'b0;
      end else if (sleep_prev && sleep_wake) begin
        wake_sent <= 1'b1;
      end
      if (i_sleep && sleep_prev && sleep_wake && !wake_sent) begin
        o_wake_to_vector <= global_irq_enable;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_TAKE_CLEARS_GIE: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    take_now |=> (o_vec.take && !global_irq_enable))
    else $error("take did not clear global enable");

  AST_VECTOR_ADDR: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    o_vec.take |-> (o_vec.vec_addr == icv_pkg::IRQ_VECTOR))
    else $error("wrong vector address");

  AST_RETURN_SETS_GIE: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (i_return_from_handler && !take_now && !wr_ctrl) |=> global_irq_enable)
    else $error("return did not set global enable");

  AST_TAKE_NEEDS_GIE: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    $rose(o_vec.take) |-> $past(global_irq_enable) && !global_irq_enable)
    else $error("interrupt taken without global enable");

  AST_EXT_FLAG: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    ext_evt |=> irq_control_reg[icv_pkg::EXT_PIN_FLAG_BIT])
    else $error("external edge did not set flag");

  AST_TIMER_FLAG: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    i_timer_overflow |=> irq_control_reg[icv_pkg::TIMER_OVERFLOW_FLAG_BIT])
    else $error("timer overflow did not set flag");

  AST_PORT_FLAG: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    port_evt |=> irq_control_reg[icv_pkg::PORT_CHANGE_FLAG_BIT])
    else $error("port change did not set flag");

  AST_PERIPH_FLAG: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    |i_periph_evt |=> |periph_flag_reg)
    else $error("peripheral event lost");

  AST_LATENCY: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (take_req && boundary && lat_cnt == 2'h0 && !wr_ctrl && !i_sleep)
      |-> ##[1:8] (take_now || !take_req))
    else $error("vector latency exceeded");

  AST_PERIPH_GATE: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (take_now && !core_req(irq_control_reg))
      |-> irq_control_reg[icv_pkg::PERIPH_GROUP_ENABLE_BIT])
    else $error("peripheral taken without group enable");

  AST_WAKE: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (i_sleep && sleep_prev && sleep_wake && !wake_sent)
      |=> (o_wake && o_wake_to_vector == $past(global_irq_enable)))
    else $error("wake not raised");

endmodule

//--- icv_pin_sync.sv
// module: two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module icv_pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta;

  // ----------------------------------------------------------------
  // first stage read only by the second
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      meta <= '0;
      o_sync <= '0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end

endmodule

//--- icv_pkg.sv
// package: constants and carriers of the interrupt flag and vector logic
package icv_pkg;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CONTROL = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_PERIPH_FLAG = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_PERIPH_ENABLE = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_OPTION = 3'h3;

  // ----------------------------------------------------------------
  // irq_control_reg fields and the option_reg edge-select bit
  // ----------------------------------------------------------------
  localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
  localparam int PERIPH_GROUP_ENABLE_BIT = 6;
  localparam int TIMER_OVERFLOW_ENABLE_BIT = 5;
  localparam int EXT_PIN_ENABLE_BIT = 4;
  localparam int PORT_CHANGE_ENABLE_BIT = 3;
  localparam int TIMER_OVERFLOW_FLAG_BIT = 2;
  localparam int EXT_PIN_FLAG_BIT = 1;
  localparam int PORT_CHANGE_FLAG_BIT = 0;
  localparam int EXT_EDGE_SELECT_BIT = 6;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] IRQ_CONTROL_RST = 8'h00;
  localparam logic [DATA_W-1:0] PERIPH_FLAG_RST = 8'h00;
  localparam logic [DATA_W-1:0] PERIPH_ENABLE_RST = 8'h00;
  localparam logic [DATA_W-1:0] OPTION_RST = 8'hff;
  localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // vector and timing
  // ----------------------------------------------------------------
  localparam int PC_W = 13;
  localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
  localparam int Q_PER_ICYC = 4;
  localparam int LAT_ICYC = 3;
  localparam int PORT_CHANGE_W = 4;
  localparam int MAX_SOURCES = 8;
  localparam int CORE_SOURCES = 3;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } icv_bus_req_s;

  typedef struct packed {
    logic take;
    logic [PC_W-1:0] vec_addr;
  } icv_vec_s;

endpackage

//--- interrupt_flag_and_vector_logic_tb_top.sv
// file: self-checking testbench of the interrupt flag and vector logic
`timescale 1ns/100ps
module interrupt_flag_and_vector_logic_tb_top;
  localparam int PN = 5;
  logic clk, rstn, pin, tov, ret_cmd, sleep, wake, wake_vec, ret;
  logic [3:0] porthi;
  logic [PN-1:0] pevt;
  logic [7:0] rdata;
  logic [icv_pkg::PC_W-1:0] pc, pc0;
  icv_pkg::icv_bus_req_s bus;
  icv_pkg::icv_vec_s vec;
  int miscompares, n_compared, n;

  icv_irq_ctrl #(.PERIPH_N(PN)) dut (.i_clk_sys(clk), .i_rstn(rstn), .i_bus(bus),
    .o_rdata(rdata), .i_ext_irq_pin(pin), .i_second_io_port_hi(porthi),
    .i_timer_overflow(tov), .i_periph_evt(pevt), .i_return_from_handler(ret),
    .i_sleep(sleep), .o_vec(vec), .o_wake(wake), .o_wake_to_vector(wake_vec));

  icv_core_model core (.i_clk_sys(clk), .i_rstn(rstn), .i_vec(vec), .i_wake(wake),
    .i_wake_to_vector(wake_vec), .i_ret_cmd(ret_cmd), .o_return_from_handler(ret),
    .o_pc(pc));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic stop_test();
    if (miscompares == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus <= '0;
  endtask

  task automatic rc(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    bus <= '0;
    #1;
    check(16'(rdata), 16'(exp));
  endtask

  task automatic pulse(input logic t, input logic [PN-1:0] p);
    @(posedge clk);
    tov <= t;
    pevt <= p;
    @(posedge clk);
    tov <= 1'b0;
    pevt <= '0;
  endtask

  task automatic pin_to(input logic v);
    @(posedge clk);
    pin <= v;
    repeat (8) @(posedge clk);
  endtask

  task automatic do_ret();
    @(posedge clk);
    ret_cmd <= 1'b1;
    @(posedge clk);
    ret_cmd <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // waits for a vector take (sel 0) or a wake (sel 1), counting edges
  task automatic wait_out(input bit sel, input int lim, output int cnt);
    cnt = 0;
    do begin
      @(posedge clk);
      #1;
      cnt++;
    end while (((sel ? wake : vec.take) !== 1'b1) && cnt < lim);
  endtask

  // ----------------------------------------------------------------
  // clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    #200000;
    miscompares++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    bus = '0;
    pin = 1'b0;
    porthi = 4'h0;
    tov = 1'b0;
    pevt = '0;
    ret_cmd = 1'b0;
    sleep = 1'b0;
    miscompares = 0;
    n_compared = 0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    rc(icv_pkg::ADDR_IRQ_CONTROL, 8'h00);
    rc(icv_pkg::ADDR_PERIPH_FLAG, 8'h00);
    rc(icv_pkg::ADDR_PERIPH_ENABLE, 8'h00);
    rc(icv_pkg::ADDR_OPTION, 8'hff);
    wr(3'h5, 8'h5a);
    rc(3'h5, 8'h00);
    // flags with every enable off
    pulse(1'b1, '0);
    rc(icv_pkg::ADDR_IRQ_CONTROL, 8'h04);
    pulse(1'b0, 5'h1f);
    rc(icv_pkg::ADDR_PERIPH_FLAG, 8'h1f);
    pin_to(1'b1);
    rc(icv_pkg::ADDR_IRQ_CONTROL, 8'h06);
    @(posedge clk);
    porthi <= 4'h9;
    repeat (8) @(posedge clk);
    rc(icv_pkg::ADDR_IRQ_CONTROL, 8'h07);
    wr(icv_pkg::ADDR_IRQ_CONTROL, 8'h00);
    wr(icv_pkg::ADDR_OPTION, 8'hbf);
    pin_to(1'b0);
    rc(icv_pkg::ADDR_IRQ_CONTROL, 8'h02);
    wr(icv_pkg::ADDR_IRQ_CONTROL, 8'h00);
    pin_to(1'b1);
    rc(icv_pkg::ADDR_IRQ_CONTROL, 8'h00);
    // masking and taking
    wr(icv_pkg::ADDR_IRQ_CONTROL, 8'h80);
    pulse(1'b1, '0);
    wait_out(1'b0, 30, n);
    check(16'(n), 16'h001e);
    rc(icv_pkg::ADDR_IRQ_CONTROL, 8'h84);
    wr(icv_pkg::ADDR_IRQ_CONTROL, 8'h24);
    wait_out(1'b0, 30, n);
    check(16'(n), 16'h001e);
    wr(icv_pkg::ADDR_IRQ_CONTROL, 8'ha4);
    wait_out(1'b0, 30, n);
    check({15'h0000, n >= 9 && n <= 12}, 16'h0001);
    check(16'(vec.vec_addr), 16'(icv_pkg::IRQ_VECTOR));
    @(posedge clk);
    #1;
    check(16'(pc), 16'(icv_pkg::IRQ_VECTOR));
    rc(icv_pkg::ADDR_IRQ_CONTROL, 8'h24);
    wr(icv_pkg::ADDR_IRQ_CONTROL, 8'h20);
    do_ret();
    rc(icv_pkg::ADDR_IRQ_CONTROL, 8'ha0);
    check(16'(pc), 16'h0000);
    wait_out(1'b0, 20, n);
    check(16'(n), 16'h0014);
    // peripheral group gate
    wr(icv_pkg::ADDR_PERIPH_ENABLE, 8'h01);
    wait_out(1'b0, 20, n);
    check(16'(n), 16'h0014);
    wr(icv_pkg::ADDR_IRQ_CONTROL, 8'hc0);
    wait_out(1'b0, 20, n);
    check({15'h0000, n <= 13}, 16'h0001);
    wr(icv_pkg::ADDR_PERIPH_FLAG, 8'h00);
    wr(icv_pkg::ADDR_PERIPH_ENABLE, 8'h00);
    do_ret();
    // wake-up with global enable off, then on
    wr(icv_pkg::ADDR_IRQ_CONTROL, 8'h10);
    sleep <= 1'b1;
    pin_to(1'b0);
    rc(icv_pkg::ADDR_IRQ_CONTROL, 8'h12);
    wr(icv_pkg::ADDR_IRQ_CONTROL, 8'h00);
    sleep <= 1'b0;
    repeat (3) @(posedge clk);
    wr(icv_pkg::ADDR_IRQ_CONTROL, 8'h10);
    sleep <= 1'b1;
    repeat (3) @(posedge clk);
    pc0 = pc;
    pin <= 1'b1;
    wait_out(1'b1, 20, n);
    check(16'(n), 16'h0014);
    pin <= 1'b0;
    wait_out(1'b1, 20, n);
    check({15'h0000, n < 20}, 16'h0001);
    check(16'(wake_vec), 16'h0000);
    @(posedge clk);
    #1;
    check(16'(pc), 16'(pc0 + 13'h0001));
    sleep <= 1'b0;
    wr(icv_pkg::ADDR_IRQ_CONTROL, 8'h00);
    sleep <= 1'b1;
    repeat (3) @(posedge clk);
    wr(icv_pkg::ADDR_IRQ_CONTROL, 8'h10);
    pin_to(1'b1);
    pin <= 1'b0;
    wait_out(1'b1, 20, n);
    check(16'(n), 16'h0014);
    rc(icv_pkg::ADDR_IRQ_CONTROL, 8'h12);
    wr(icv_pkg::ADDR_IRQ_CONTROL, 8'ha0);
    pulse(1'b1, '0);
    wait_out(1'b1, 20, n);
    check(16'(wake_vec), 16'h0001);
    @(posedge clk);
    #1;
    check(16'(pc), 16'(icv_pkg::IRQ_VECTOR));
    rc(icv_pkg::ADDR_IRQ_CONTROL, 8'ha4);
    wr(icv_pkg::ADDR_IRQ_CONTROL, 8'h20);
    sleep <= 1'b0;
    // reset in mid-run
    wr(icv_pkg::ADDR_IRQ_CONTROL, 8'hb8);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rc(icv_pkg::ADDR_IRQ_CONTROL, 8'h00);
    repeat (6) @(posedge clk);
    rc(icv_pkg::ADDR_IRQ_CONTROL, 8'h00);
    stop_test();
  end
endmodule
